/* src/cpd_card_pin_ctrl.sv */
// card pin control, card detect and removal deactivation with register bus
`timescale 1ns/1ps
`default_nettype none

module cpd_card_pin_ctrl (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // axi4-lite write address channel
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [cpd_pkg::ADDR_W-1:0] I_AWADDR,
    input wire logic [2:0] I_AWPROT,
    // axi4-lite write data channel
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [cpd_pkg::DATA_W-1:0] I_WDATA,
    input wire logic [cpd_pkg::STRB_W-1:0] I_WSTRB,
    // axi4-lite write response channel
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    // axi4-lite read address channel
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [cpd_pkg::ADDR_W-1:0] I_ARADDR,
    input wire logic [2:0] I_ARPROT,
    // axi4-lite read data channel
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [cpd_pkg::DATA_W-1:0] O_RDATA,
    output logic [1:0] O_RRESP,
    // card side pins
    input wire logic I_CARD_DETECT_PIN,
    input wire logic I_CARD_DATA_OUTPUT_ENABLE_PIN,
    output logic O_CARD_DATA_OUT_DRIVE,
    output logic O_CARD_CLK_KEEP,
    // neighbouring control and sequencer logic
    input wire logic I_INTERFACE_ENABLE_BIT,
    input wire cpd_pkg::cpd_seq_t I_SEQ,
    output logic O_ABORT_OPERATION,
    output logic O_DEACT_START,
    input wire logic I_DEACT_DONE,
    // interrupts
    output logic O_INIT_END,
    output logic O_IRQ
);

    import cpd_pkg::*;

    // pin synchronisers
    logic [1:0] pins_async;
    logic [1:0] pins_sync;
    logic detect_s;
    logic oen_s;

    assign pins_async = {I_CARD_DATA_OUTPUT_ENABLE_PIN, I_CARD_DETECT_PIN};

    cpd_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    assign detect_s = pins_sync[0];
    assign oen_s = pins_sync[1];

    // write channel: address and data are taken independently
    logic aw_hold_q;
    logic w_hold_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    cpd_wr_t wr_q;
    logic aw_fire;
    logic w_fire;
    logic wr_fire;

    assign O_AWREADY = !aw_hold_q && !bvalid_q;
    assign O_WREADY = !w_hold_q && !bvalid_q;
    assign aw_fire = I_AWVALID && O_AWREADY;
    assign w_fire = I_WVALID && O_WREADY;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            aw_hold_q <= 1'b0;
            wr_q.addr <= '0;
        end else if (aw_fire) begin
            aw_hold_q <= 1'b1;
            wr_q.addr <= I_AWADDR;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            w_hold_q <= 1'b0;
            wr_q.data <= '0;
            wr_q.strb <= '0;
        end else if (w_fire) begin
            w_hold_q <= 1'b1;
            wr_q.data <= I_WDATA;
            wr_q.strb <= I_WSTRB;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    // write decode
    logic hit_pin_w;
    logic hit_clr_w;
    logic hit_en_w;
    logic hit_stat_w;
    logic wr_pin;
    logic wr_pin_lo;
    logic wr_pin_hi;
    logic wr_clr;
    logic wr_en;
    logic wr_mapped;

    assign hit_pin_w = wr_q.addr == OFF_PIN_CTRL;
    assign hit_clr_w = wr_q.addr == OFF_IRQ_CLR;
    assign hit_en_w = wr_q.addr == OFF_IRQ_EN;
    assign hit_stat_w = wr_q.addr == OFF_IRQ_STAT;
    assign wr_mapped = hit_pin_w || hit_clr_w || hit_en_w || hit_stat_w;
    assign wr_pin = wr_fire && hit_pin_w;
    assign wr_pin_lo = wr_pin && wr_q.strb[LANE_LOW];
    assign wr_pin_hi = wr_pin && wr_q.strb[LANE_HIGH];
    assign wr_clr = wr_fire && hit_clr_w && wr_q.strb[LANE_LOW];
    assign wr_en = wr_fire && hit_en_w && wr_q.strb[LANE_LOW];

    // status register writes are accepted and have no effect
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (I_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;

    // card detect edges, gated by the interface enable
    logic detect_prev_q;
    logic det_rise;
    logic det_fall;
    logic insert_ev;
    logic remove_ev;
    logic det_pol_q;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            detect_prev_q <= 1'b0;
        end else begin
            detect_prev_q <= detect_s;
        end
    end

    assign det_rise = detect_s && !detect_prev_q;
    assign det_fall = !detect_s && detect_prev_q;
    // polarity is sampled live, so it must be settled before enabling
    assign insert_ev = I_INTERFACE_ENABLE_BIT
        && (det_pol_q ? det_rise : det_fall);
    assign remove_ev = I_INTERFACE_ENABLE_BIT
        && (det_pol_q ? det_fall : det_rise);

    // software controlled pin bits
    logic auto_deact_q;
    logic data_out_q;
    logic clk_keep_q;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            det_pol_q <= RST_DET_POL;
            auto_deact_q <= RST_AUTO_DEACT;
        end else begin
            if (wr_pin_hi) begin
                det_pol_q <= wr_q.data[BIT_DET_POL];
            end
            if (wr_pin_lo) begin
                auto_deact_q <= wr_q.data[BIT_AUTO_DEACT];
            end
        end
    end

    // the sequencer owns these bits while it runs; bus writes are dropped
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            data_out_q <= RST_DATA_OUT;
            clk_keep_q <= RST_CLK_KEEP;
        end else if (I_SEQ.busy) begin
            data_out_q <= I_SEQ.data_out;
            clk_keep_q <= I_SEQ.clk_keep;
        end else begin
            if (wr_pin_hi) begin
                data_out_q <= wr_q.data[BIT_DATA_OUT];
            end
            if (wr_pin_lo) begin
                clk_keep_q <= wr_q.data[BIT_CLK_KEEP];
            end
        end
    end

    assign O_CARD_DATA_OUT_DRIVE = data_out_q;
    assign O_CARD_CLK_KEEP = clk_keep_q;

    // sticky insert and remove flags; a new event beats a clear
    logic ins_flag_q;
    logic rem_flag_q;
    logic clr_ins;
    logic clr_rem;

    assign clr_ins = wr_pin_lo && wr_q.data[BIT_INS_FLAG];
    assign clr_rem = wr_pin_lo && wr_q.data[BIT_REM_FLAG];

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ins_flag_q <= 1'b0;
            rem_flag_q <= 1'b0;
        end else begin
            ins_flag_q <= (ins_flag_q && !clr_ins) || insert_ev;
            rem_flag_q <= (rem_flag_q && !clr_rem) || remove_ev;
        end
    end

    // automatic deactivation on removal
    cpd_deact_state_t deact_state_q;
    cpd_deact_state_t deact_state_d;
    logic deact_end;

    always_comb begin
        deact_state_d = deact_state_q;
        case (deact_state_q)
            ST_IDLE: begin
                if (remove_ev && auto_deact_q) begin
                    deact_state_d = ST_ABORT;
                end
            end
            ST_ABORT: begin
                deact_state_d = ST_START;
            end
            ST_START: begin
                deact_state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (I_DEACT_DONE) begin
                    deact_state_d = ST_IDLE;
                end
            end
            default: begin
                deact_state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            deact_state_q <= ST_IDLE;
        end else begin
            deact_state_q <= deact_state_d;
        end
    end

    assign O_ABORT_OPERATION = deact_state_q == ST_ABORT;
    assign O_DEACT_START = deact_state_q == ST_START;
    // only removal-driven deactivations report here
    assign deact_end = (deact_state_q == ST_WAIT) && I_DEACT_DONE;

    logic init_end_q;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            init_end_q <= 1'b0;
        end else begin
            init_end_q <= deact_end;
        end
    end

    assign O_INIT_END = init_end_q;

    // interrupt status, clear and enable
    logic [IRQ_N-1:0] irq_ev;
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_en_q;
    logic [IRQ_N-1:0] irq_clr;
    logic irq_q;

    assign irq_ev[IRQ_INSERT] = insert_ev;
    assign irq_ev[IRQ_REMOVE] = remove_ev;
    assign irq_ev[IRQ_DEACT_END] = deact_end;
    assign irq_clr = wr_clr ? wr_q.data[IRQ_N-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
            always_ff @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    irq_stat_q[gi] <= 1'b0;
                end else begin
                    irq_stat_q[gi] <= (irq_stat_q[gi] && !irq_clr[gi])
                        || irq_ev[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_en_q <= RST_IRQ_EN;
            irq_q <= 1'b0;
        end else begin
            if (wr_en) begin
                irq_en_q <= wr_q.data[IRQ_N-1:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    assign O_IRQ = irq_q;

    // read path: one read in flight, data held until taken
    logic [DATA_W-1:0] pin_rd;
    logic [DATA_W-1:0] rd_word;
    logic rd_mapped;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_fire;

    always_comb begin
        pin_rd = '0;
        pin_rd[BIT_DET_POL] = det_pol_q;
        pin_rd[BIT_DATA_OUT] = data_out_q;
        pin_rd[BIT_OEN_ST] = oen_s;
        pin_rd[BIT_AUTO_DEACT] = auto_deact_q;
        pin_rd[BIT_CLK_KEEP] = clk_keep_q;
        pin_rd[BIT_DET_LEVEL] = detect_s;
        pin_rd[BIT_INS_FLAG] = ins_flag_q;
        pin_rd[BIT_REM_FLAG] = rem_flag_q;
    end

    assign rd_mapped = I_ARADDR == OFF_PIN_CTRL || I_ARADDR == OFF_IRQ_STAT
        || I_ARADDR == OFF_IRQ_CLR || I_ARADDR == OFF_IRQ_EN;
    assign rd_word = (I_ARADDR == OFF_PIN_CTRL) ? pin_rd
        : (I_ARADDR == OFF_IRQ_STAT) ? {{(DATA_W-IRQ_N){1'b0}}, irq_stat_q}
        : (I_ARADDR == OFF_IRQ_EN) ? {{(DATA_W-IRQ_N){1'b0}}, irq_en_q}
        : '0;

    assign O_ARREADY = !rvalid_q;
    assign ar_fire = I_ARVALID && O_ARREADY;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign O_RVALID = rvalid_q;
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;

endmodule
`default_nettype wire

/* inc/cpd_pkg.sv */
// constants and types shared by the card pin control and detect block
package cpd_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PIN_CTRL = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h48;

    // pin control register field positions
    localparam int BIT_DET_POL = 10;
    localparam int BIT_DATA_OUT = 9;
    localparam int BIT_OEN_ST = 8;
    localparam int BIT_AUTO_DEACT = 7;
    localparam int BIT_CLK_KEEP = 6;
    localparam int BIT_DET_LEVEL = 4;
    localparam int BIT_INS_FLAG = 3;
    localparam int BIT_REM_FLAG = 2;

    // byte lanes carrying those fields
    localparam int LANE_LOW = 0;
    localparam int LANE_HIGH = 1;

    // pin control reset values
    localparam logic RST_DET_POL = 1'b0;
    localparam logic RST_DATA_OUT = 1'b0;
    localparam logic RST_AUTO_DEACT = 1'b0;
    localparam logic RST_CLK_KEEP = 1'b0;

    // interrupt status, clear and enable layout
    localparam int IRQ_N = 3;
    localparam int IRQ_INSERT = 0;
    localparam int IRQ_REMOVE = 1;
    localparam int IRQ_DEACT_END = 2;
    localparam logic [IRQ_N-1:0] RST_IRQ_EN = 3'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // automatic deactivation sequence on removal
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ABORT,
        ST_START,
        ST_WAIT
    } cpd_deact_state_t;

    // what the running activation, warm reset or deactivation sequencer owns
    typedef struct packed {
        logic busy;
        logic data_out;
        logic clk_keep;
    } cpd_seq_t;

    // a decoded register write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } cpd_wr_t;

endpackage

/* src/cpd_pin_sync.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module cpd_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // asynchronous pins and their synchronised levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // the first stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule
`default_nettype wire

/* verif/cpd_card_pin_ctrl_sva.sv */
// port assertions for the card pin control and detect block
`timescale 1ns/1ps
`default_nettype none

module cpd_card_pin_ctrl_chk (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // register bus handshakes
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic [cpd_pkg::DATA_W-1:0] O_RDATA,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    // card pins and sequencer side
    input wire logic O_CARD_DATA_OUT_DRIVE,
    input wire logic O_CARD_CLK_KEEP,
    input wire logic I_INTERFACE_ENABLE_BIT,
    input wire cpd_pkg::cpd_seq_t I_SEQ,
    input wire logic O_ABORT_OPERATION,
    input wire logic O_DEACT_START,
    input wire logic I_DEACT_DONE,
    input wire logic O_INIT_END
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    read_answer_a:
        assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read data late after address");
    read_hold_a:
        assert property (O_RVALID && !I_RREADY
            |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped before ready");
    write_hold_a:
        assert property (O_BVALID && !I_BREADY |=> O_BVALID)
        else $error("write response dropped before ready");
    deact_order_a:
        assert property (O_ABORT_OPERATION
            |=> O_DEACT_START && !O_ABORT_OPERATION)
        else $error("deactivation start does not follow abort");
    start_cause_a:
        assert property (O_DEACT_START |-> $past(O_ABORT_OPERATION))
        else $error("deactivation start without abort");
    init_end_cause_a:
        assert property (O_INIT_END |-> $past(I_DEACT_DONE))
        else $error("initial end without finished deactivation");
    abort_gate_a:
        assert property (O_ABORT_OPERATION |-> $past(I_INTERFACE_ENABLE_BIT))
        else $error("abort while interface disabled");
    seq_data_a:
        assert property (I_SEQ.busy
            |=> O_CARD_DATA_OUT_DRIVE == $past(I_SEQ.data_out))
        else $error("data out not following sequencer");
    seq_clock_a:
        assert property (I_SEQ.busy
            |=> O_CARD_CLK_KEEP == $past(I_SEQ.clk_keep))
        else $error("clock keep not following sequencer");
    drive_cause_a:
        assert property ($changed(O_CARD_DATA_OUT_DRIVE)
            |-> $past(I_SEQ.busy) || $rose(O_BVALID))
        else $error("data out changed without write or sequencer");
endmodule

`default_nettype wire

/* verif/cpd_card_model.sv */
// behavioural card and card-detect switch facing the pin control block
`timescale 1ns/1ps
`default_nettype none

module cpd_card_model (
    // pins read by the block
    output logic o_detect,
    output logic o_oen
);
    initial begin
        o_detect = 1'b1;
        o_oen = 1'b0;
    end
    // switch sits at the insert level only while a card is in
    task automatic set(input logic pol, input logic in, input logic oe);
        o_detect <= in ? pol : !pol;
        o_oen <= oe;
    endtask
endmodule

`default_nettype wire

/* verif/cpd_card_pin_ctrl_tb.sv */
// self-checking bench for the card pin control and detect block
`timescale 1ns/1ps
`default_nettype none

module cpd_card_pin_ctrl_tb;
    import cpd_pkg::*;
    logic clk, rst, awv, wv, bry, arv, rry, en, done;
    logic [ADDR_W-1:0] awa, ara;
    logic [DATA_W-1:0] wd, rd_q, ctl;
    logic [STRB_W-1:0] ws;
    logic [1:0] resp;
    cpd_seq_t seq;
    wire awr, wrr, bv, arr, rv, drv, ck, abt, dst, ie, irq, det, oen;
    wire [1:0] br, rr;
    wire [DATA_W-1:0] rdat;
    int num_errors, samples_checked, cyc, n;

    cpd_card_pin_ctrl dut (
        .I_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_AWADDR(awa), .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(wrr),
        .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry),
        .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
        .I_ARPROT(3'h0), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat),
        .O_RRESP(rr), .I_CARD_DETECT_PIN(det),
        .I_CARD_DATA_OUTPUT_ENABLE_PIN(oen), .O_CARD_DATA_OUT_DRIVE(drv),
        .O_CARD_CLK_KEEP(ck), .I_INTERFACE_ENABLE_BIT(en), .I_SEQ(seq),
        .O_ABORT_OPERATION(abt), .O_DEACT_START(dst),
        .I_DEACT_DONE(done), .O_INIT_END(ie), .O_IRQ(irq));

    cpd_card_model card (.o_detect(det), .o_oen(oen));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask

    // bready rides with the request unless late, which makes bvalid wait
    task wr(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s = 4'hF, input bit late = 1'b0);
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= !late;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
            if (bv && !bry) bry <= 1'b1;
        end while (!(bv && bry));
        resp = br;
        bry <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input bit late = 1'b0);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= !late;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv && !rry) rry <= 1'b1;
        end while (!(rv && rry));
        rd_q = rdat;
        resp = rr;
        rry <= 1'b0;
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
              input logic [31:0] e);
        rd(a);
        chk(nm, rd_q & m, e);
    endtask

    initial begin
        rst = 1'b1;
        {awv, wv, bry, arv, rry, en, done} = '0;
        seq = '0;
        {awa, ara, wd, ws} = '0;
        num_errors = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // the detect level reads 0 until both sync stages have filled
        repeat (2) @(posedge clk);
        rchk("pin reset", OFF_PIN_CTRL, 32'hFFFFFFFF, 32'h10);
        rd(OFF_IRQ_EN, 1'b1);
        chk("irq en reset", rd_q, 32'h0);
        rd(8'h80);
        chk("bad read", {resp, rd_q[29:0]}, {RESP_DECERR, 30'h0});
        wr(8'h80, 32'hFFFFFFFF, 4'hF, 1'b1);
        chk("bad write", resp, RESP_DECERR);
        wr(OFF_IRQ_STAT, 32'h7);
        chk("stat write", resp, RESP_OKAY);
        rchk("stat ro", OFF_IRQ_STAT, 32'h7, 32'h0);
        card.set(1'b0, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        rchk("no detect off", OFF_PIN_CTRL, 32'hC, 32'h0);
        card.set(1'b0, 1'b0, 1'b0);
        // data out and clock keep by write, lane 1 left out on the second
        wr(OFF_PIN_CTRL, 32'h240);
        chk("drive", {drv, ck}, 2'h3);
        rchk("drive rb", OFF_PIN_CTRL, 32'h240, 32'h240);
        wr(OFF_PIN_CTRL, 32'h0, 4'h1);
        chk("lane", {drv, ck}, 2'h2);
        @(posedge clk);
        seq <= 3'b100;
        wr(OFF_PIN_CTRL, 32'h240);
        chk("seq low", {drv, ck}, 2'h0);
        @(posedge clk);
        seq <= 3'b111;
        repeat (2) @(posedge clk);
        chk("seq high", {drv, ck}, 2'h3);
        seq <= 3'b000;
        wr(OFF_PIN_CTRL, 32'h0);
        chk("drive off", {drv, ck}, 2'h0);
        for (int p = 0; p < 2; p++) begin
            ctl = 32'((p << BIT_DET_POL) | (p << BIT_AUTO_DEACT));
            @(posedge clk);
            en <= 1'b0;
            card.set(p[0], 1'b0, p[0]);
            wr(OFF_PIN_CTRL, ctl | 32'hC);
            wr(OFF_IRQ_CLR, 32'h7);
            wr(OFF_IRQ_EN, 32'h1);
            @(posedge clk);
            en <= 1'b1;
            card.set(p[0], 1'b1, p[0]);
            repeat (8) @(posedge clk);
            rchk("insert", OFF_PIN_CTRL, 32'h11C,
                 32'(8 | (p << 4) | (p << 8)));
            chk("irq raised", irq, 1'b1);
            wr(OFF_PIN_CTRL, ctl);
            rchk("ins keep", OFF_PIN_CTRL, 32'h8, 32'h8);
            wr(OFF_PIN_CTRL, ctl | 32'h8);
            rchk("ins clear", OFF_PIN_CTRL, 32'h8, 32'h0);
            wr(OFF_IRQ_CLR, 32'h1);
            repeat (2) @(posedge clk);
            chk("irq cleared", irq, 1'b0);
            card.set(p[0], 1'b0, p[0]);
            n = 0;
            while (!abt && n < 20) begin
                @(posedge clk);
                n++;
            end
            chk("abort", abt, p[0]);
            if (p == 1) begin
                @(posedge clk);
                chk("deact start", dst, 1'b1);
                repeat (3) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
                n = 0;
                while (!ie && n < 6) begin
                    @(posedge clk);
                    n++;
                end
                chk("init end", ie, 1'b1);
            end
            rchk("status", OFF_IRQ_STAT, 32'h7, p ? 32'h6 : 32'h2);
            chk("irq masked", irq, 1'b0);
            rchk("removed", OFF_PIN_CTRL, 32'h4, 32'h4);
            wr(OFF_PIN_CTRL, ctl);
            rchk("rem keep", OFF_PIN_CTRL, 32'h4, 32'h4);
            wr(OFF_PIN_CTRL, ctl | 32'h4);
            rchk("rem clear", OFF_PIN_CTRL, 32'h4, 32'h0);
        end
        end_sim();
    end
endmodule

bind cpd_card_pin_ctrl cpd_card_pin_ctrl_chk u_chk (.I_CLK, .I_RST,
    .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA, .O_BVALID,
    .I_BREADY, .O_CARD_DATA_OUT_DRIVE, .O_CARD_CLK_KEEP, .I_SEQ,
    .I_INTERFACE_ENABLE_BIT, .O_ABORT_OPERATION, .O_DEACT_START,
    .I_DEACT_DONE, .O_INIT_END);

`default_nettype wire
